// ==== shared/ass_regs.svh ====
`ifndef ASS_REGS_SVH
`define ASS_REGS_SVH
// ----------------------------------------------------------------------
// Constants
// ----------------------------------------------------------------------
`define ASS_CHAN_RST 4'h0
`define ASS_REF_RST 2'h0
`define ASS_REF_VCC 2'h0
`define ASS_REF_EXT 2'h1
`define ASS_REF_INT 2'h2
`define ASS_FULL_SCALE 10'h3FF
`define ASS_CONV_CYC 5'h0D
`define ASS_FIRST_CYC 5'h19
`define ASS_PRESC_RST 7'h00
`endif

// ==== shared/ass_pkg.sv ====
package ass_pkg;
   typedef struct packed {
      logic [1:0] reference_select;
      logic [3:0] channel_select;
   } ass_sel_t;

   typedef enum logic [2:0] {
      ASS_IDLE = 3'h1,
      ASS_WAIT = 3'h2,
      ASS_CONV = 3'h4
   } ass_state_t;

   typedef struct packed {
      ass_state_t state;
      ass_sel_t eff;
      logic [6:0] presc;
      logic [4:0] cnt;
      logic first;
      logic single;
      logic start_bit;
      logic done_flag;
      logic irq;
      logic [9:0] result;
      logic trig_s1;
      logic trig_s2;
      logic trig_d;
      logic sleep_s1;
      logic sleep_s2;
      logic sleep_d;
      ass_sel_t sel_out;
      logic sample;
   } ass_st_t;
endpackage : ass_pkg

// ==== hw/ass_sequencer.sv ====
`timescale 1ns/1ns
`include "ass_regs.svh"
module ass_sequencer
   import ass_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic clk_en,
   // Software control
   input wire logic converter_enable,
   input wire logic start_write,
   input wire logic auto_trigger_enable,
   input wire logic free_running,
   input wire logic irq_enable,
   input wire logic done_clear,
   input wire logic [2:0] prescale_sel,
   input wire ass_sel_t input_select_register,
   // Outside events and analog core
   input wire logic trigger_in,
   input wire logic sleep_quiet,
   input wire logic [9:0] core_code,
   input wire logic core_over,
   // Status and analog control
   output logic conversion_start_bit,
   output logic conversion_done_flag,
   output logic irq,
   output logic [7:0] result_low,
   output logic [7:0] result_high,
   output ass_sel_t sel_out,
   output logic sample
);
   ass_st_t s_q, s_d;
   logic tick;
   logic trig_edge;
   logic sleep_edge;
   logic last_cyc;
   logic [4:0] len;

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      tick = (s_q.presc == ((7'h01 << prescale_sel) - 7'h01));
      len = s_q.first ? `ASS_FIRST_CYC : `ASS_CONV_CYC;
      last_cyc = (s_q.state == ASS_CONV) && tick && (s_q.cnt == len - 5'h01);
      trig_edge = s_q.trig_s2 && !s_q.trig_d;
      sleep_edge = s_q.sleep_s2 && !s_q.sleep_d;
      // Outside inputs pass two flops; the second one and a one-cycle delayed copy of it feed the edge logic.
      s_d.trig_s1 = trigger_in;
      s_d.trig_s2 = s_q.trig_s1;
      s_d.trig_d = s_q.trig_s2;
      s_d.sleep_s1 = sleep_quiet;
      s_d.sleep_s2 = s_q.sleep_s1;
      s_d.sleep_d = s_q.sleep_s2;
      s_d.presc = tick ? `ASS_PRESC_RST : s_q.presc + 7'h01;
      s_d.irq = 1'b0;
      s_d.sample = 1'b0;
      if (s_q.done_flag && done_clear) begin
         s_d.done_flag = 1'b0;
      end
      if (!converter_enable) begin
         s_d.state = ASS_IDLE;
         s_d.presc = `ASS_PRESC_RST;
         s_d.first = 1'b1;
         s_d.start_bit = 1'b0;
         s_d.eff = input_select_register;
      end else begin
         unique case (s_q.state)
            ASS_IDLE: begin
               s_d.eff = input_select_register;
               if (auto_trigger_enable && trig_edge && !s_q.done_flag) begin
                  s_d.presc = `ASS_PRESC_RST;
                  s_d.state = ASS_CONV;
                  s_d.cnt = 5'h00;
                  s_d.start_bit = 1'b1;
                  s_d.single = 1'b0;
               end else if (start_write || (sleep_edge && irq_enable
                            && !auto_trigger_enable)) begin
                  s_d.state = ASS_WAIT;
                  s_d.start_bit = 1'b1;
                  s_d.single = 1'b1;
               end
            end
            ASS_WAIT: begin
               s_d.eff = input_select_register;
               if (tick) begin
                  s_d.state = ASS_CONV;
                  s_d.cnt = 5'h00;
               end
            end
            ASS_CONV: begin
               if (tick) begin
                  s_d.cnt = s_q.cnt + 5'h01;
                  if (s_q.cnt == 5'h01) begin
                     s_d.sample = 1'b1;
                  end
               end
               if (s_q.cnt == len - 5'h01) begin
                  s_d.eff = input_select_register;
               end
               if (last_cyc) begin
                  // An input above the reference pins the code at full scale.
                  s_d.result = core_over ? `ASS_FULL_SCALE
                                         : core_code;
                  s_d.done_flag = 1'b1;
                  s_d.irq = irq_enable;
                  s_d.first = 1'b0;
                  if (auto_trigger_enable && free_running) begin
                     s_d.cnt = 5'h00;
                  end else begin
                     s_d.state = ASS_IDLE;
                     s_d.start_bit = 1'b0;
                  end
               end
            end
            default: s_d.state = ASS_IDLE;
         endcase
      end
      s_d.sel_out = s_q.eff;
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
         s_q.state <= ASS_IDLE;
         s_q.first <= 1'b1;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign conversion_start_bit = s_q.start_bit;
   assign conversion_done_flag = s_q.done_flag;
   assign irq = s_q.irq;
   assign result_low = s_q.result[7:0];
   assign result_high = {6'h00, s_q.result[9:8]};
   assign sel_out = s_q.sel_out;
   assign sample = s_q.sample;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   property p_idle_track;
      @(posedge clk) disable iff (!nrst)
      (clk_en && s_q.state == ASS_IDLE)
         |=> s_q.eff == $past(input_select_register);
   endproperty
   a_idle_track: assert property (p_idle_track)
      else $error("idle selection not tracking");

   property p_lock;
      @(posedge clk) disable iff (!nrst)
      (clk_en && converter_enable && s_q.state == ASS_CONV
       && s_q.cnt != len - 5'h01) |=> $stable(s_q.eff);
   endproperty
   a_lock: assert property (p_lock)
      else $error("selection moved during conversion");

   property p_done_result;
      @(posedge clk) disable iff (!nrst)
      (clk_en && converter_enable && last_cyc) |=> s_q.done_flag
         && s_q.result == $past(core_over ? `ASS_FULL_SCALE : core_code);
   endproperty
   a_done_result: assert property (p_done_result)
      else $error("result and flag not set together");

   property p_busy_bit;
      @(posedge clk) disable iff (!nrst)
      (s_q.state == ASS_CONV) |-> s_q.start_bit;
   endproperty
   a_busy_bit: assert property (p_busy_bit)
      else $error("start bit low during conversion");

   property p_hold;
      @(posedge clk) disable iff (!nrst)
      (clk_en && !(converter_enable && last_cyc)) |=> $stable(s_q.result);
   endproperty
   a_hold: assert property (p_hold)
      else $error("result changed outside completion");

   property p_start;
      @(posedge clk) disable iff (!nrst)
      (clk_en && converter_enable && s_q.state == ASS_WAIT && tick)
         |=> s_q.state == ASS_CONV && s_q.cnt == 5'h00;
   endproperty
   a_start: assert property (p_start)
      else $error("conversion did not begin on tick");

   property p_trig;
      @(posedge clk) disable iff (!nrst)
      (clk_en && converter_enable && s_q.state == ASS_IDLE
       && auto_trigger_enable && trig_edge && !s_q.done_flag)
         |=> s_q.presc == 7'h00 && s_q.state == ASS_CONV;
   endproperty
   a_trig: assert property (p_trig)
      else $error("trigger did not start conversion");

   property p_off;
      @(posedge clk) disable iff (!nrst)
      (clk_en && !converter_enable) |=> s_q.state == ASS_IDLE
         && !s_q.start_bit;
   endproperty
   a_off: assert property (p_off)
      else $error("disabled converter still busy");

   property p_wait_track;
      @(posedge clk) disable iff (!nrst)
      (clk_en && converter_enable && s_q.state == ASS_WAIT)
         |=> s_q.eff == $past(input_select_register);
   endproperty
   a_wait_track: assert property (p_wait_track)
      else $error("selection not tracking before start");

   property p_last_refresh;
      @(posedge clk) disable iff (!nrst)
      (clk_en && converter_enable && s_q.state == ASS_CONV
       && s_q.cnt == len - 5'h01)
         |=> s_q.eff == $past(input_select_register);
   endproperty
   a_last_refresh: assert property (p_last_refresh)
      else $error("selection not refreshed in last cycle");

   property p_sel_copy;
      @(posedge clk) disable iff (!nrst)
      clk_en |=> s_q.sel_out == $past(s_q.eff);
   endproperty
   a_sel_copy: assert property (p_sel_copy)
      else $error("shown selection differs from effective one");

   property p_free_run;
      @(posedge clk) disable iff (!nrst)
      (clk_en && converter_enable && last_cyc && auto_trigger_enable
       && free_running)
         |=> s_q.state == ASS_CONV && s_q.cnt == 5'h00 && s_q.start_bit;
   endproperty
   a_free_run: assert property (p_free_run)
      else $error("free running did not restart");

   property p_single_end;
      @(posedge clk) disable iff (!nrst)
      (clk_en && converter_enable && last_cyc
       && !(auto_trigger_enable && free_running))
         |=> s_q.state == ASS_IDLE && !s_q.start_bit;
   endproperty
   a_single_end: assert property (p_single_end)
      else $error("start bit not cleared at completion");

   property p_irq_set;
      @(posedge clk) disable iff (!nrst)
      (clk_en && converter_enable && last_cyc)
         |=> s_q.irq == $past(irq_enable);
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("completion request not raised");

   property p_irq_pulse;
      @(posedge clk) disable iff (!nrst)
      (clk_en && !(converter_enable && last_cyc)) |=> !s_q.irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse)
      else $error("request raised outside completion");

   property p_sleep_start;
      @(posedge clk) disable iff (!nrst)
      (clk_en && converter_enable && s_q.state == ASS_IDLE && sleep_edge
       && irq_enable && !auto_trigger_enable)
         |=> s_q.state == ASS_WAIT && s_q.start_bit && s_q.single;
   endproperty
   a_sleep_start: assert property (p_sleep_start)
      else $error("halt did not start a conversion");

   property p_count;
      @(posedge clk) disable iff (!nrst)
      (clk_en && converter_enable && s_q.state == ASS_CONV && tick
       && s_q.cnt != len - 5'h01)
         |=> s_q.cnt == $past(s_q.cnt) + 5'h01;
   endproperty
   a_count: assert property (p_count)
      else $error("converter clock count skipped");

   property p_over;
      @(posedge clk) disable iff (!nrst)
      (clk_en && converter_enable && last_cyc && core_over)
         |=> s_q.result == `ASS_FULL_SCALE;
   endproperty
   a_over: assert property (p_over)
      else $error("over-range input not at full scale");

   property p_clear;
      @(posedge clk) disable iff (!nrst)
      (clk_en && done_clear && !(converter_enable && last_cyc))
         |=> !s_q.done_flag;
   endproperty
   a_clear: assert property (p_clear)
      else $error("done flag not cleared");
endmodule : ass_sequencer

// ==== tb/ass_core_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Analog core stand-in
// ----------------------------------------------------------------------
module ass_core_model
   import ass_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Converter side
   input wire ass_sel_t sel_out,
   input wire logic sample,
   output logic [9:0] core_code,
   output logic core_over
);
   // The code is held from one sample to the next, as a hold stage does.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         core_code <= 10'h2AA;
         core_over <= 1'b0;
      end else if (sample) begin
         core_code <= {sel_out, 4'h5};
         core_over <= (sel_out.channel_select == 4'hB);
      end
   end
endmodule : ass_core_model

// ==== tb/ass_sequencer_tb.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
// ----------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------
module ass_sequencer_tb;
   import ass_pkg::*;
   logic clk, nrst, clk_en, converter_enable, start_write, done_clear;
   logic auto_trigger_enable, free_running, irq_enable, trigger_in;
   logic sleep_quiet, core_over, conversion_start_bit, irq, sample;
   logic conversion_done_flag, irq_seen;
   logic [2:0] prescale_sel;
   logic [9:0] core_code;
   logic [7:0] result_low, result_high;
   ass_sel_t input_select_register, sel_out;
   int err_total, cmp_count, cyc, tmo;
   ass_sequencer u_dut (.clk, .nrst, .clk_en, .converter_enable,
      .start_write, .auto_trigger_enable, .free_running, .irq_enable,
      .done_clear, .prescale_sel, .input_select_register, .trigger_in,
      .sleep_quiet, .core_code, .core_over, .conversion_start_bit,
      .conversion_done_flag, .irq, .result_low, .result_high, .sel_out,
      .sample);
   ass_core_model u_core (.clk, .nrst, .sel_out, .sample, .core_code,
      .core_over);
   task automatic give_verdict;
      if (err_total == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic tick(int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic hit(ref logic s);
      @(negedge clk) s = 1'b1;
      @(negedge clk) s = 1'b0;
   endtask : hit
   task automatic wait_done(int lo, int hi);
      cyc = 0;
      irq_seen = 1'b0;
      while (conversion_done_flag !== 1'b1 && cyc < 100) begin
         @(negedge clk);
         cyc++;
         if (irq === 1'b1) irq_seen = 1'b1;
      end
      `CHK(cyc inside {[lo:hi]}, 1'b1)
   endtask : wait_done
   // Checks the held result, then clears the flag.
   task automatic chk_res(ass_sel_t s);
      logic [9:0] e;
      e = (s.channel_select == 4'hB) ? 10'h3FF : {s, 4'h5};
      `CHK(conversion_done_flag, 1'b1)
      tick(2);
      `CHK({result_high, result_low}, {6'h00, e})
      hit(done_clear);
      `CHK(conversion_done_flag, 1'b0)
   endtask : chk_res
   task automatic conv(ass_sel_t s, int lo, int hi);
      @(negedge clk) input_select_register = s;
      hit(start_write);
      `CHK(conversion_start_bit, 1'b1)
      wait_done(lo, hi);
      `CHK(conversion_start_bit, free_running)
      `CHK(irq_seen, irq_enable)
      chk_res(s);
   endtask : conv
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // A hang is cut short well after the whole sequence should be over.
   always @(posedge clk) begin
      tmo++;
      if (tmo == 20000) begin
         err_total++;
         give_verdict();
      end
   end
   initial begin
      {nrst, converter_enable, start_write, done_clear} = '0;
      {auto_trigger_enable, free_running, irq_enable, trigger_in} = '0;
      {sleep_quiet, prescale_sel, input_select_register} = '0;
      clk_en = 1'b1;
      tick(10);
      `CHK({conversion_start_bit, conversion_done_flag, sel_out},
         8'h00)
      nrst = 1'b1;
      input_select_register = 6'h23;
      tick(3);
      `CHK(sel_out, 6'h23)
      converter_enable = 1'b1;
      conv(6'h01, 24, 28);
      conv(6'h1B, 12, 16);
      for (int r = 0; r < 3; r++) begin
         repeat (2) conv({r[1:0], 4'h4}, 12, 28);
      end
      input_select_register = 6'h07;
      hit(start_write);
      tick(1);
      input_select_register = 6'h09;
      tick(3);
      `CHK(sel_out, 6'h07)
      wait_done(6, 16);
      chk_res(6'h07);
      `CHK(sel_out, 6'h09)
      conv(6'h09, 12, 16);
      {auto_trigger_enable, free_running} = 2'h3;
      conv(6'h02, 12, 16);
      input_select_register = 6'h03;
      wait_done(8, 16);
      `CHK(conversion_start_bit, 1'b1)
      chk_res(6'h02);
      wait_done(8, 16);
      chk_res(6'h03);
      {converter_enable, free_running} = 2'h0;
      input_select_register = 6'h05;
      tick(3);
      `CHK({conversion_start_bit, sel_out}, 7'h05)
      converter_enable = 1'b1;
      tick(2);
      trigger_in = 1'b1;
      wait_done(24, 34);
      chk_res(6'h05);
      {trigger_in, auto_trigger_enable, irq_enable} = 3'h1;
      input_select_register = 6'h06;
      tick(2);
      sleep_quiet = 1'b1;
      wait_done(12, 22);
      `CHK(irq_seen, 1'b1)
      chk_res(6'h06);
      sleep_quiet = 1'b0;
      prescale_sel = 3'h1;
      conv(6'h0A, 26, 30);
      give_verdict();
   end
endmodule : ass_sequencer_tb
